// ### hdl/tone_digit_detect_timing.v
// Tone presence, guard-time qualification and digit strobe of the tone receiver.
`timescale 1ns/1ps
`include "tone_digit_regs.vh"

// Contract
// - Tone presence is recognised within 5 to 16.8 ms with gain control off, 5 to 44 ms on.
// - Tone disappearance is recognised within 0.5 to 8.5 ms.
// - A tone is accepted after 54.5 ms (gain off, guard 0100) or 54 ms (gain on, guard 0001); the code accepts after about 46.1 ms and 31.4 ms.
// - A tone burst of 32.2 ms or less is rejected with default guard settings; with gain on the code accepts bursts over about 27.2 ms.
// - A gap of at least 28.4 ms is a true interdigit pause with default guard settings.
// - Dropouts of 1.6 ms or less are ignored and never count as pauses.
// - Accept and reject thresholds scale with the present and absent guard settings.
// - The digit-valid strobe rises 21.7 us after the guard timer expires.
// - The stored code is updated just before the digit-valid strobe goes high.
module tone_digit_detect_timing #(
    parameter CODE_W     = `CODE_W,
    parameter DP_CYC_OFF = `US_TO_CYC(`TDP_MAX_AGC_OFF_US) / 2, // Presence debounce.
    parameter DP_CYC_ON  = `US_TO_CYC(`TDP_MAX_AGC_ON_US) / 2,
    parameter DA_CYC     = `US_TO_CYC(`TDA_MAX_US) / 2,         // Absence debounce.
    parameter GTP_UNIT   = `US_TO_CYC(`TREC_AGC_OFF_US - `TDP_MAX_AGC_OFF_US) / 4,
    parameter GTA_UNIT   = `US_TO_CYC(`TID_US - `TDA_MAX_US) / 4,
    parameter PSTD_CYC   = `NS_TO_CYC(`TPSTD_NS)
) (
    input  wire              clk,                   // System clock, 100 MHz.
    input  wire              sys_rst,               // Synchronous reset, active high.
    input  wire              tone_raw,              // Raw tone energy detect, asynchronous.
    input  wire [CODE_W-1:0] tone_code,             // Code of the present tone pair.
    input  wire              agc_enable,            // Gain control on.
    input  wire [3:0]        present_guard_setting, // Guard time while tone present.
    input  wire [3:0]        absent_guard_setting,  // Guard time while tone absent.
    input  wire              code_load_strobe_n,    // Host load strobe, low active, async.
    input  wire              shift_clock,           // Host shift clock, async.
    output reg               digit_valid_strobe,    // High while a valid digit is held.
    output reg [CODE_W-1:0]  digit_code,            // Stored decoded digit.
    output wire              serial_code_out,       // Serial code bit.
    output wire              serial_code_oe_n       // Low while serial pin is driven.
);

    localparam CW = 24;
    localparam ST_IDLE  = 2'h0;
    localparam ST_GUARD = 2'h1;
    localparam ST_DELAY = 2'h2;
    localparam ST_HOLD  = 2'h3;

    // Guard threshold grows with the setting; setting zero still gives one unit.
    function [CW-1:0] guard_cycles;
        input [3:0]    setting;
        input [CW-1:0] unit;
        begin
            guard_cycles = (setting == 4'h0) ? unit : setting * unit;
        end
    endfunction

    // Two-stage synchronisers for the three asynchronous pin inputs.
    reg [1:0] tone_s;
    reg [1:0] load_s;
    reg [1:0] shift_s;
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            tone_s  <= 2'h0;
            load_s  <= 2'h3;
            shift_s <= 2'h0;
        end
        else
        begin
            tone_s  <= {tone_s[0], tone_raw};
            load_s  <= {load_s[0], code_load_strobe_n};
            shift_s <= {shift_s[0], shift_clock};
        end
    end

    // Debounced presence; the debounce times sit inside the detection windows.
    reg          present;
    reg [CW-1:0] deb_cnt;
    wire [CW-1:0] dp_lim = agc_enable ? DP_CYC_ON[CW-1:0] : DP_CYC_OFF[CW-1:0];
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            present <= 1'b0;
            deb_cnt <= {CW{1'b0}};
        end
        else if (tone_s[1] == present)
            deb_cnt <= {CW{1'b0}};
        else if (!present && deb_cnt >= dp_lim - 1'b1)
        begin
            present <= 1'b1;
            deb_cnt <= {CW{1'b0}};
        end
        else if (present && deb_cnt >= DA_CYC[CW-1:0] - 1'b1)
        begin
            present <= 1'b0;
            deb_cnt <= {CW{1'b0}};
        end
        else
            deb_cnt <= deb_cnt + 1'b1;
    end

    // Guard timer: a tone must persist the present guard to be accepted, and
    // a gap must persist the absent guard before another digit is allowed.
    // A short dropout resets only the gap count, so it never ends a digit.
    reg [1:0]    state;
    reg [CW-1:0] guard_timer;
    reg [CW-1:0] gap_cnt;
    reg [CODE_W-1:0] code_hold;
    wire [CW-1:0] gtp_lim = guard_cycles(present_guard_setting, GTP_UNIT[CW-1:0]);
    wire [CW-1:0] gta_lim = guard_cycles(absent_guard_setting, GTA_UNIT[CW-1:0]);
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            state              <= ST_IDLE;
            guard_timer        <= {CW{1'b0}};
            gap_cnt            <= {CW{1'b0}};
            code_hold          <= {CODE_W{1'b0}};
            digit_code         <= {CODE_W{1'b0}};
            digit_valid_strobe <= 1'b0;
        end
        else
        begin
            case (state)
            ST_IDLE:
            begin
                guard_timer <= {CW{1'b0}};
                if (present)
                begin
                    state     <= ST_GUARD;
                    code_hold <= tone_code;
                end
            end
            ST_GUARD:
            begin
                if (!present)
                    state <= ST_IDLE;
                else if (guard_timer >= gtp_lim - 1'b1)
                begin
                    state       <= ST_DELAY;
                    guard_timer <= {CW{1'b0}};
                end
                else
                    guard_timer <= guard_timer + 1'b1;
            end
            ST_DELAY:
            begin
                if (guard_timer >= PSTD_CYC[CW-1:0] - 1'b1)
                begin
                    state       <= ST_HOLD;
                    gap_cnt     <= {CW{1'b0}};
                    digit_code  <= code_hold;
                end
                else
                    guard_timer <= guard_timer + 1'b1;
                // Strobe follows one cycle after the code so the code is stable.
            end
            ST_HOLD:
            begin
                digit_valid_strobe <= 1'b1;
                if (present)
                    gap_cnt <= {CW{1'b0}};
                else if (gap_cnt >= gta_lim - 1'b1)
                begin
                    state              <= ST_IDLE;
                    digit_valid_strobe <= 1'b0;
                end
                else
                    gap_cnt <= gap_cnt + 1'b1;
            end
            default:
                state <= ST_IDLE;
            endcase
        end
    end

    // The host reads only after the strobe rose; no extra wait is enforced here.
    code_shifter #(
        .CODE_W (CODE_W)
    ) u_shift (
        .clk         (clk),
        .sys_rst     (sys_rst),
        .code        (digit_code),
        .load_n_sync (load_s[1]),
        .shift_sync  (shift_s[1]),
        .sd_out      (serial_code_out),
        .sd_oe_n     (serial_code_oe_n)
    );

endmodule

// ### hdl/tone_digit_regs.vh
// Timing constants and field layout for the tone digit receiver.
`ifndef TONE_DIGIT_REGS_VH
`define TONE_DIGIT_REGS_VH

// Clock period in picoseconds (100 MHz).
`define CLK_PERIOD_PS        10000
// Tone present detection time, longest (AGC off / on) and least, in microseconds.
`define TDP_MAX_AGC_OFF_US   16800
`define TDP_MAX_AGC_ON_US    44000
`define TDP_MIN_US           5000
// Tone absent detection time, in microseconds (least and longest).
`define TDA_MIN_US           500
`define TDA_MAX_US           8500
// Accept time with default present guard, in microseconds (AGC off / on).
`define TREC_AGC_OFF_US      54500
`define TREC_AGC_ON_US       54000
// Reject time, in microseconds.
`define TREJ_US              32200
// Interdigit pause accept time and dropout reject time, in microseconds.
`define TID_US               28400
`define TDO_US               1600
// Guard timer to strobe delay, in nanoseconds.
`define TPSTD_NS             21700
// Default guard settings.
`define GTP_DEFAULT_OFF      4'h4
`define GTP_DEFAULT_ON       4'h1
`define GTA_DEFAULT          4'h4
// Width of the decoded digit code.
`define CODE_W               4
// Cycles per microsecond and per nanosecond conversions.
`define US_TO_CYC(us)        (((us) * 1000000) / `CLK_PERIOD_PS)
`define NS_TO_CYC(ns)        (((ns) * 1000) / `CLK_PERIOD_PS)

`endif

// ### hdl/code_shifter.v
// Serial readout of the decoded digit code, loaded by strobe and shifted by clock.
`timescale 1ns/1ps
`include "tone_digit_regs.vh"

module code_shifter #(
    parameter CODE_W = `CODE_W
) (
    input  wire              clk,          // System clock.
    input  wire              sys_rst,      // Synchronous reset, active high.
    input  wire [CODE_W-1:0] code,         // Stored digit code.
    input  wire              load_n_sync,  // Synchronised load strobe, low active.
    input  wire              shift_sync,   // Synchronised shift clock.
    output reg               sd_out,       // Serial data value.
    output reg               sd_oe_n       // Low while the pin is driven.
);

    reg [CODE_W-1:0] shreg;
    reg              load_n_d;
    reg              shift_d;

    // Load on the falling load strobe, shift on each rising shift clock while the strobe stays low and is not just falling; the
    // output floats whenever the load strobe is high so a shared line stays free.
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            shreg    <= {CODE_W{1'b0}};
            load_n_d <= 1'b1;
            shift_d  <= 1'b0;
            sd_out   <= 1'b0;
            sd_oe_n  <= 1'b1;
        end
        else
        begin
            load_n_d <= load_n_sync;
            shift_d  <= shift_sync;
            if (load_n_d && !load_n_sync)
            begin
                shreg   <= code;
                sd_out  <= code[CODE_W-1];
                sd_oe_n <= 1'b0;
            end
            else if (load_n_sync)
            begin
                sd_oe_n <= 1'b1;
            end
            else if (shift_sync && !shift_d)
            begin
                shreg  <= {shreg[CODE_W-2:0], 1'b0};
                sd_out <= shreg[CODE_W-2];
            end
        end
    end

endmodule

// ### verif/tone_digit_checker.sv
// Port-level assertions for the tone digit receiver.
`timescale 1ns/1ps
module tone_digit_checker #(
    parameter CODE_W    = 4,
    parameter DP_CYC_ON = 40,
    parameter DA_CYC    = 10,
    parameter GTP_UNIT  = 10,
    parameter GTA_UNIT  = 10,
    parameter PSTD_CYC  = 5
) (
    input wire              clk,                // System clock.
    input wire              sys_rst,            // Synchronous reset.
    input wire              tone_raw,           // Raw tone level.
    input wire              code_load_strobe_n, // Host load strobe.
    input wire              digit_valid_strobe, // Digit strobe.
    input wire [CODE_W-1:0] digit_code,         // Stored code.
    input wire              serial_code_oe_n    // Serial pin enable.
);
    // Worst-case limits take the largest guard setting plus synchroniser slack.
    localparam int ACC_LIM = 7 + DP_CYC_ON + 15 * GTP_UNIT + PSTD_CYC;
    localparam int GAP_LIM = 7 + DA_CYC + 15 * GTA_UNIT;
    reg [15:0] high_run;
    reg [15:0] low_run;
    // Run lengths of the raw tone level.
    always @(posedge clk)
    begin
        high_run <= (sys_rst || !tone_raw) ? 16'h0 : high_run + 16'h1;
        low_run  <= (sys_rst || tone_raw) ? 16'h0 : low_run + 16'h1;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence long_quiet;
        !tone_raw[*8] ##1 !tone_raw[*8];
    endsequence
    sequence held_then_drop;
        tone_raw[*8] ##1 (!tone_raw && digit_valid_strobe);
    endsequence
    code_stable_a: assert property (
        digit_valid_strobe && $past(digit_valid_strobe) |-> $stable(digit_code))
        else $error("code moved under strobe");
    code_then_strobe_a: assert property (
        $changed(digit_code) |=> $rose(digit_valid_strobe)) else $error("code without strobe");
    oe_off_a: assert property (
        code_load_strobe_n[*5] |=> serial_code_oe_n) else $error("pin driven while idle");
    oe_on_a: assert property (
        !code_load_strobe_n[*5] |=> !serial_code_oe_n) else $error("pin not driven on load");
    quiet_no_strobe_a: assert property (
        long_quiet |-> !$rose(digit_valid_strobe)) else $error("strobe without tone");
    dropout_hold_a: assert property (
        held_then_drop |=> digit_valid_strobe[*8]) else $error("dropout ended digit");
    gap_release_a: assert property (
        low_run == GAP_LIM |-> !digit_valid_strobe) else $error("pause not accepted");
    accept_due_a: assert property (
        high_run == ACC_LIM |-> digit_valid_strobe) else $error("tone not accepted");
endmodule

bind tone_digit_detect_timing tone_digit_checker #(
    .CODE_W(CODE_W), .DP_CYC_ON(DP_CYC_ON), .DA_CYC(DA_CYC),
    .GTP_UNIT(GTP_UNIT), .GTA_UNIT(GTA_UNIT), .PSTD_CYC(PSTD_CYC)
) tone_digit_checker_i (
    .clk(clk), .sys_rst(sys_rst), .tone_raw(tone_raw),
    .code_load_strobe_n(code_load_strobe_n), .digit_valid_strobe(digit_valid_strobe),
    .digit_code(digit_code), .serial_code_oe_n(serial_code_oe_n)
);

// ### verif/host_reader.sv
// Host model that fetches a decoded digit over the load and shift lines.
`timescale 1ns/1ps
module host_reader (
    input  wire clk,                // Bench clock, paces the host.
    input  wire serial_code_out,    // Serial bit from the receiver.
    input  wire serial_code_oe_n,   // Low while the receiver drives.
    output reg  code_load_strobe_n, // Load strobe, low active.
    output reg  shift_clock         // Shift clock.
);
    reg  last_bit = 1'b0;
    wire pin;
    // A released pin toggles every cycle, so a float never passes for data.
    assign pin = serial_code_oe_n ? ~last_bit : serial_code_out;
    always @(posedge clk)
    begin
        last_bit <= pin;
    end
    initial
    begin
        code_load_strobe_n = 1'b1;
        shift_clock = 1'b0;
    end
    // Slow host: every shift phase is 500 ns, far above the few cycles the receiver needs.
    task fetch(output reg [3:0] code);
        integer i;
        begin
            repeat (10) @(negedge clk);
            code_load_strobe_n = 1'b0;
            for (i = 3; i >= 0; i = i - 1)
            begin
                repeat (50) @(negedge clk);
                code[i] = pin;
                shift_clock = 1'b1;
                repeat (50) @(negedge clk);
                shift_clock = 1'b0;
            end
            code_load_strobe_n = 1'b1;
            repeat (10) @(negedge clk);
        end
    endtask
endmodule

// ### verif/tb_top.sv
// Self-checking bench for the tone digit receiver.
`timescale 1ns/1ps
module tb_top;
    reg        clk = 1'b0;
    reg        sys_rst = 1'b1;
    reg        tone_raw = 1'b0;
    reg  [3:0] tone_code = 4'h0;
    reg        agc = 1'b0;
    reg  [3:0] gp = 4'h4;
    reg  [3:0] ga = 4'h4;
    wire       load_n;
    wire       shift_clk;
    wire       strobe;
    wire [3:0] code;
    wire       sd;
    wire       sd_oe_n;
    integer    num_errors = 0;
    integer    checks = 0;
    // Free-running 100 MHz clock.
    always #5 clk = ~clk;
    tone_digit_detect_timing #(
        .DP_CYC_OFF(20), .DP_CYC_ON(40), .DA_CYC(10),
        .GTP_UNIT(10), .GTA_UNIT(10), .PSTD_CYC(5)
    ) tone_digit_detect_timing_i (
        .clk(clk), .sys_rst(sys_rst), .tone_raw(tone_raw), .tone_code(tone_code),
        .agc_enable(agc), .present_guard_setting(gp), .absent_guard_setting(ga),
        .code_load_strobe_n(load_n), .shift_clock(shift_clk), .digit_valid_strobe(strobe),
        .digit_code(code), .serial_code_out(sd), .serial_code_oe_n(sd_oe_n)
    );
    host_reader host_reader_i (
        .clk(clk), .serial_code_out(sd), .serial_code_oe_n(sd_oe_n),
        .code_load_strobe_n(load_n), .shift_clock(shift_clk)
    );
    // Tolerance covers the synchroniser's uncertain first cycle.
    task compare(input string what, input integer exp, input [15:0] got, input integer tol);
        begin
            checks = checks + 1;
            if ((^got === 1'bx) || got + tol < exp || got > exp + tol)
            begin
                num_errors = num_errors + 1;
                $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
            end
        end
    endtask
    task wait_level(input lvl, output integer n);
        begin
            n = 0;
            while (strobe !== lvl && n < 1000)
            begin
                @(negedge clk);
                n = n + 1;
            end
        end
    endtask
    task tally_and_finish;
        begin
            $display("checks %0d num_errors %0d", checks, num_errors);
            if (num_errors == 0 && checks > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    // One digit: accept time, stored and serial code, dropout, then pause.
    task run_digit(input a_on, input [3:0] p, input [3:0] a, input [3:0] c);
        integer   n;
        reg [3:0] got;
        begin
            @(negedge clk);
            agc = a_on;
            gp = p;
            ga = a;
            tone_code = c;
            tone_raw = 1'b1;
            wait_level(1'b1, n);
            compare("rise", (a_on ? 40 : 20) + 10 * (p == 0 ? 1 : p) + 10, n, 3);
            compare("code", c, code, 0);
            host_reader_i.fetch(got);
            compare("serial", c, got, 0);
            compare("float", 1, sd_oe_n, 0);
            tone_raw = 1'b0;
            repeat (5) @(negedge clk);
            tone_raw = 1'b1;
            repeat (20) @(negedge clk);
            compare("hold", 1, strobe, 0);
            tone_raw = 1'b0;
            wait_level(1'b0, n);
            compare("gap", 13 + 10 * (a == 0 ? 1 : a), n, 3);
        end
    endtask
    // A burst too short to accept must leave strobe and code alone.
    task reject_burst(input [3:0] prev);
        integer n;
        begin
            @(negedge clk);
            agc = 1'b0;
            gp = 4'h4;
            tone_code = 4'h3;
            tone_raw = 1'b1;
            repeat (45) @(negedge clk);
            tone_raw = 1'b0;
            wait_level(1'b1, n);
            compare("reject", 1000, n, 0);
            compare("kept", prev, code, 0);
        end
    endtask
    initial
    begin
        repeat (8) @(negedge clk);
        sys_rst = 1'b0;
        run_digit(1'b0, 4'h4, 4'h4, 4'h9);
        run_digit(1'b1, 4'h8, 4'h2, 4'ha);
        run_digit(1'b0, 4'h0, 4'h0, 4'h6);
        reject_burst(4'h6);
        tally_and_finish;
    end
    // Watchdog well beyond the few thousand cycles the tests need.
    initial
    begin
        #100000;
        num_errors = num_errors + 1;
        tally_and_finish;
    end
endmodule
